/* File: verilog/vistat_pkg.sv */
// Package of constants and types for the IACK status/ID block
package vistat_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [11:0] VISTAT_OUTGOING_VECTOR_OFS = 12'h320;
  localparam logic [11:0] VISTAT_LEVEL1_VECTOR_OFS = 12'h324;
  localparam logic [11:0] VISTAT_LEVEL2_VECTOR_OFS = 12'h328;
  localparam logic [11:0] VISTAT_LEVEL3_VECTOR_OFS = 12'h32C;
  localparam logic [11:0] VISTAT_IRQ_ENABLE_OFS = 12'h340;
  localparam logic [11:0] VISTAT_IRQ_STATUS_OFS = 12'h344;
  localparam logic [11:0] VISTAT_INT_STATUS_OFS = 12'h348;
  localparam logic [11:0] VISTAT_INT_MASK_OFS = 12'h34C;
  localparam logic [11:0] VISTAT_SW_IRQ_OFS = 12'h350;

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int VISTAT_LEVELS = 3;
  localparam int VISTAT_OUT_LSB = 24;
  localparam int VISTAT_ERR_BIT = 8;
  localparam logic [6:0] VISTAT_ID_RESET = 7'h7F;
  localparam logic [7:0] VISTAT_VEC_RESET = 8'h00;
  localparam logic [31:0] VISTAT_ZERO_WORD = 32'h0000_0000;
  localparam logic [31:0] VISTAT_UNMAPPED_WORD = 32'hDEAD_BEEF;

  // Captured vector: byte plus bus error flag
  typedef struct packed {
    logic err;
    logic [7:0] vec;
  } vistat_capture_type;

  // Handler state machine
  typedef enum logic [1:0] {
    VISTAT_IDLE,
    VISTAT_ACK,
    VISTAT_DONE
  } vistat_state_type;

endpackage

/* File: verilog/vistat_top.sv */
// IACK status/ID block: interrupter vector out and handler vector capture
// Scope: three handler levels only; mapping local sources onto bus levels
// lives elsewhere. Every register here resets synchronously with rst, and
// the request lines arrive already de-inverted and synchronous to clock.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps

module vistat_top
  import vistat_pkg::*;
#(
  parameter int LEVELS = VISTAT_LEVELS
) (
  input wire logic clock,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupter side: incoming acknowledge
  input wire logic iack_in_req,
  input wire logic [2:0] iack_in_level,
  output logic [7:0] iack_out_vector,
  output logic iack_out_valid,
  // Handler side: request lines and our own acknowledge
  input wire logic [LEVELS:1] vme_level_bit,
  output logic iack_req,
  output logic [2:0] iack_level,
  input wire logic iack_done,
  input wire logic [7:0] iack_vector,
  input wire logic iack_berr,
  output logic irq
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // Software-visible state; each level field sits at word bits [LEVELS:1]
  logic [6:0] outgoing_id_r;
  logic [LEVELS:1] local_irq_enable_reg;
  logic [LEVELS:1] local_irq_status_reg;
  logic [LEVELS:1] software_irq_pending;
  logic [LEVELS:1] int_status_r;
  logic [LEVELS:1] int_mask_r;
  // Handler capture per level and the sequencer that fills it
  vistat_capture_type level_captured_vector [LEVELS:1];
  vistat_state_type state_r;
  logic [2:0] cur_level_r;
  // Decoded strobes and the combinational read word
  logic [LEVELS:1] capture_evt;
  logic rd_accept;
  logic wr_accept;
  logic [31:0] rd_word;

  // Byte lane mask for a 32-bit write
  // Each enable bit widens to the eight data bits of its lane
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Word write helper under byte enables
  // Lanes that are not enabled keep their old contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    merge = (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // Level field of a write under byte enables; word bit 0 is unused, so the
  // stored bits go back to their word position before the merge
  function automatic logic [LEVELS:1] level_write(input logic [LEVELS:1] old,
                                                  input logic [31:0] wd,
                                                  input logic [3:0] be);
    logic [31:0] word;
    word = merge(32'({old, 1'b0}), wd, be);
    level_write = word[LEVELS:1];
  endfunction

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // One wait state: request seen, answer on the next edge.
  // Walk of a read: edge 0 sees the request with waitrequest high, loads the
  // read word and drops waitrequest; edge 1 is the accepting edge where the
  // master takes the data and a write lands. Back-to-back requests are fine.
  assign rd_accept = avs_read && !avs_waitrequest;
  assign wr_accept = avs_write && !avs_waitrequest;

  // Waitrequest high by default; drops one cycle after a request
  // Registered, so the master sees a clean level straight from a flip-flop
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Software writes land only at the accepting edge. Read-only and unknown
  // offsets fall through every compare below, so such writes are dropped.
  // Only byte lane 3 carries the identity, so its enable gates the write
  // identity field written by software
  always_ff @(posedge clock) begin
    if (rst) begin
      outgoing_id_r <= VISTAT_ID_RESET;
    end else if (wr_accept && avs_address == VISTAT_OUTGOING_VECTOR_OFS && avs_byteenable[3]) begin
      outgoing_id_r <= avs_writedata[VISTAT_OUT_LSB + 7:VISTAT_OUT_LSB + 1];
    end
  end

  // Enable, mask and software request bits
  // Partial writes keep the level bits of lanes that are not enabled
  always_ff @(posedge clock) begin
    if (rst) begin
      local_irq_enable_reg <= '0;
      int_mask_r <= '0;
      software_irq_pending <= '0;
    end else if (wr_accept) begin
      if (avs_address == VISTAT_IRQ_ENABLE_OFS) begin
        local_irq_enable_reg <= level_write(local_irq_enable_reg, avs_writedata,
                                            avs_byteenable);
      end
      if (avs_address == VISTAT_INT_MASK_OFS) begin
        int_mask_r <= level_write(int_mask_r, avs_writedata, avs_byteenable);
      end
      if (avs_address == VISTAT_SW_IRQ_OFS) begin
        software_irq_pending <= level_write(software_irq_pending, avs_writedata,
                                            avs_byteenable);
      end
    end
  end

  // ---------------------------------------------------------------
  // Handler: acknowledge sequencer
  // ---------------------------------------------------------------
  // Lowest eligible level wins; one acknowledge cycle at a time
  // The scan runs from the top level down, so the last hit (lowest) sticks.
  // Trade-off: a busy low level holds off higher ones for one acknowledge cycle only,
  // as its set status bit then blocks it; levels are few, so no rotating priority is kept.
  // Walk: IDLE sees a line and raises the request; ACK waits for the done
  // pulse and captures there; DONE is one idle cycle before the next scan.
  // The request and its level stand unchanged for the whole cycle.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= VISTAT_IDLE;
      cur_level_r <= 3'h0;
      iack_req <= 1'b0;
      iack_level <= 3'h0;
    end else begin
      case (state_r)
        VISTAT_IDLE: begin
          for (int i = LEVELS; i >= 1; i--) begin
            if (vme_level_bit[i] && local_irq_enable_reg[i] && !local_irq_status_reg[i]) begin
              state_r <= VISTAT_ACK;
              cur_level_r <= 3'(i);
              iack_level <= 3'(i);
              iack_req <= 1'b1;
            end
          end
        end
        VISTAT_ACK: begin
          // Vector and flag come with done; nothing is sampled before it
          // ends by vector or bus error
          if (iack_done) begin
            iack_req <= 1'b0;
            state_r <= VISTAT_DONE;
          end
        end
        VISTAT_DONE: begin
          // Gap cycle lets status bit settle before rescanning
          state_r <= VISTAT_IDLE;
        end
        default: begin
          // Only a corrupted code lands here; fall back to a clean idle
          state_r <= VISTAT_IDLE;
          iack_req <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Per-level capture and status
  // ---------------------------------------------------------------
  // One slice per level; the capture strobe below feeds the vector,
  // the handler status bit and the sticky event bit of that level
  genvar g;
  generate
    for (g = 1; g <= LEVELS; g++) begin : g_level
      assign capture_evt[g] = (state_r == VISTAT_ACK) && iack_done && (cur_level_r == 3'(g));

      // Byte and flag are taken together at the done edge
      // and then stand until the next capture at this level
      // vector captured per level
      always_ff @(posedge clock) begin
        if (rst) begin
          level_captured_vector[g] <= '{err: 1'b0, vec: VISTAT_VEC_RESET};
        end else if (capture_evt[g]) begin
          level_captured_vector[g] <= '{err: iack_berr, vec: iack_vector};
        end
      end

      // Clearing needs byte lane 0, where the level bits live
      // write one to clear; a capture wins over the clear
      always_ff @(posedge clock) begin
        if (rst) begin
          local_irq_status_reg[g] <= 1'b0;
        end else if (capture_evt[g]) begin
          local_irq_status_reg[g] <= 1'b1;
        end else if (wr_accept && avs_address == VISTAT_IRQ_STATUS_OFS &&
                     avs_byteenable[0] && avs_writedata[g]) begin
          local_irq_status_reg[g] <= 1'b0;
        end
      end

      // Sticky event bit, cleared by reading; a new event beats the read.
      // Only bits that the read word returned are cleared: an event at the
      // edge that loads the read word would otherwise be lost unseen.
      always_ff @(posedge clock) begin
        if (rst) begin
          int_status_r[g] <= 1'b0;
        end else if (capture_evt[g]) begin
          int_status_r[g] <= 1'b1;
        end else if (rd_accept && avs_address == VISTAT_INT_STATUS_OFS &&
                     avs_readdata[g]) begin
          int_status_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Level interrupt from unmasked sticky bits
  // Registered, so irq follows a status or mask change by one cycle;
  // it stays high until the sticky bits are read or masked off
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_r & int_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // Interrupter: answer to an incoming acknowledge
  // ---------------------------------------------------------------
  // Valid follows the request by one edge and stands while it stays high.
  // A level outside 1..LEVELS never matches a pending request, so bit 0
  // then answers 1, the same as a level with nothing pending.
  // return vector byte
  // bit 0 low when software irq pending at this level
  always_ff @(posedge clock) begin
    if (rst) begin
      iack_out_vector <= VISTAT_VEC_RESET;
      iack_out_valid <= 1'b0;
    end else begin
      iack_out_valid <= iack_in_req;
      if (iack_in_req) begin
        iack_out_vector <= {outgoing_id_r,
          !((iack_in_level >= 3'h1) && (iack_in_level <= 3'(LEVELS)) &&
            software_irq_pending[iack_in_level])};
      end
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Word layout seen by software:
  //   outgoing vector: identity in the top byte above a constant 1
  //   captured vectors: byte in [7:0], bus error flag in [8], read-only
  //   enable, handler status (write one to clear), sticky status (clear on
  //   read), mask and software request: one bit per level at [LEVELS:1]
  //   anything else reads a fixed marker word and ignores writes
  always_comb begin
    rd_word = VISTAT_UNMAPPED_WORD;
    case (avs_address)
      VISTAT_OUTGOING_VECTOR_OFS: begin
        // Bit 0 reads as the current answer bit for no level
        rd_word = {outgoing_id_r, 1'b1, 24'h000000};
      end
      VISTAT_LEVEL1_VECTOR_OFS: begin
        rd_word = 32'(level_captured_vector[1]);
      end
      VISTAT_LEVEL2_VECTOR_OFS: begin
        rd_word = 32'(level_captured_vector[2]);
      end
      VISTAT_LEVEL3_VECTOR_OFS: begin
        rd_word = 32'(level_captured_vector[3]);
      end
      VISTAT_IRQ_ENABLE_OFS: begin
        rd_word = 32'({local_irq_enable_reg, 1'b0});
      end
      VISTAT_IRQ_STATUS_OFS: begin
        rd_word = 32'({local_irq_status_reg, 1'b0});
      end
      VISTAT_INT_STATUS_OFS: begin
        rd_word = 32'({int_status_r, 1'b0});
      end
      VISTAT_INT_MASK_OFS: begin
        rd_word = 32'({int_mask_r, 1'b0});
      end
      VISTAT_SW_IRQ_OFS: begin
        rd_word = 32'({software_irq_pending, 1'b0});
      end
      default: begin
        rd_word = VISTAT_UNMAPPED_WORD;
      end
    endcase
  end

  // Read data registered at the answering edge
  // Loaded only while waiting, so it still stands at the accepting edge
  always_ff @(posedge clock) begin
    if (rst) begin
      avs_readdata <= VISTAT_ZERO_WORD;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_word;
    end
  end

endmodule

/* File: verif/vistat_top_asserts.sv */
// Port-level concurrent checks for the IACK status/ID block
`timescale 1ns/10ps
module vistat_chk
  import vistat_pkg::*;
#(
  parameter int LEVELS = VISTAT_LEVELS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic iack_in_req,
  input wire logic iack_out_valid,
  input wire logic [LEVELS:1] vme_level_bit,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic iack_done,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // Helpers and sequences
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [LEVELS:1] lines_q;
  // Line levels as the handler saw them one edge earlier
  always_ff @(posedge clock) begin
    lines_q <= vme_level_bit;
  end
  sequence ack_start_s;
    $rose(iack_req);
  endsequence
  sequence ack_fin_s;
    iack_req && iack_done;
  endsequence
  sequence bus_new_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  reset_idle_a: assert property ($fell(rst) |-> avs_waitrequest && !iack_req && !irq)
    else $error("outputs not idle after reset");
  reset_vec_a: assert property ($fell(rst) |-> !iack_out_valid && iack_level == 3'h0)
    else $error("vector or level not cleared by reset");
  wait_one_a: assert property (bus_new_s |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");
  vec_valid_a: assert property (iack_in_req |=> iack_out_valid)
    else $error("no vector after acknowledge");
  vec_quiet_a: assert property (!iack_in_req |=> !iack_out_valid)
    else $error("vector without acknowledge");
  ack_line_a: assert property (ack_start_s |-> iack_level inside {[1:3]} && lines_q[iack_level])
    else $error("acknowledge on a quiet level");
  ack_hold_a: assert property (iack_req && !iack_done |=> iack_req && $stable(iack_level))
    else $error("acknowledge dropped early");
  ack_end_a: assert property (ack_fin_s |=> !iack_req)
    else $error("acknowledge not ended by done");
endmodule

bind vistat_top vistat_chk #(.LEVELS(LEVELS)) u_chk (.clock(clock), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .iack_in_req(iack_in_req), .iack_out_valid(iack_out_valid), .vme_level_bit(vme_level_bit),
  .iack_req(iack_req), .iack_level(iack_level), .iack_done(iack_done), .irq(irq));

/* File: verif/vistat_far_model.sv */
// Far-side model: interrupters answering the block's acknowledge cycles
`timescale 1ns/10ps
module vistat_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:1] raise,
  input wire logic [2:0] berr_level,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  output logic [3:1] vme_level_bit,
  output logic iack_done,
  output logic [7:0] iack_vector,
  output logic iack_berr
);
  logic [3:0] wait_r;
  // Lines stay up until released, as a release-on-register interrupter
  assign vme_level_bit = raise;
  // vector or bus error
  // Delay grows with level so both fast and slow answers occur
  always_ff @(posedge clock) begin
    iack_done <= 1'b0;
    iack_vector <= ~iack_vector;
    iack_berr <= ~iack_berr;
    if (rst) begin
      wait_r <= 4'h0;
      iack_vector <= 8'h00;
      iack_berr <= 1'b0;
    end else if (iack_req && !iack_done) begin
      if (wait_r == {iack_level, 1'b0}) begin
        iack_done <= 1'b1;
        iack_vector <= 8'hC0 | {5'h00, iack_level};
        iack_berr <= (iack_level == berr_level);
        wait_r <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

/* File: verif/vistat_top_tb.sv */
// Register-level testbench for the IACK status/ID block
`timescale 1ns/10ps
module vistat_top_tb
  import vistat_pkg::*;
;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, iack_in_req, iack_out_valid;
  logic iack_req, iack_done, iack_berr, irq, req_q;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [2:0] iack_in_level, iack_level, berr_level;
  logic [7:0] iack_out_vector, iack_vector;
  logic [3:1] vme_level_bit, raise;
  int error_cnt = 0, checked = 0, rises = 0, n0;
  vistat_top u_dut (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .iack_in_req, .iack_in_level,
    .iack_out_vector, .iack_out_valid, .vme_level_bit, .iack_req, .iack_level, .iack_done,
    .iack_vector, .iack_berr, .irq);
  vistat_far_model u_far (.clock, .rst, .raise, .berr_level, .iack_req, .iack_level,
    .vme_level_bit, .iack_done, .iack_vector, .iack_berr);
  // ---------------------------------------------------------------
  // Clock, counters and bus tasks
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Count handler acknowledge starts
  always @(posedge clock) begin
    if (iack_req === 1'b1 && req_q !== 1'b1) rises++;
    req_q = iack_req;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // No limit of its own; the watchdog ends a hung wait
    do begin
      @(posedge clock);
      if (avs_waitrequest !== 1'b0) n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("wait states", 32'h1, 32'(n));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk("readdata", exp, q);
  endtask
  task automatic poll(input logic [11:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    do acc(1'b0, a, 32'h0); while (q !== exp && ++n < 40);
    chk("polled", exp, q);
  endtask
  task automatic conclude;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    conclude;
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst, avs_read, avs_write, iack_in_req} = 4'h8;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    iack_in_level = 3'h0;
    raise = 3'h0;
    berr_level = 3'h1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(VISTAT_OUTGOING_VECTOR_OFS, 32'hFF00_0000);
    for (int i = 1; i <= 3; i++) rd(12'h320 + 12'(4 * i), 32'h0);
    rd(12'h3F0, VISTAT_UNMAPPED_WORD);
    acc(1'b1, VISTAT_OUTGOING_VECTOR_OFS, 32'h5400_0000);
    acc(1'b1, VISTAT_LEVEL1_VECTOR_OFS, 32'hFFFF_FFFF);
    rd(VISTAT_OUTGOING_VECTOR_OFS, 32'h5500_0000);
    rd(VISTAT_LEVEL1_VECTOR_OFS, 32'h0);
    acc(1'b1, VISTAT_SW_IRQ_OFS, 32'h4);
    // Back-to-back acknowledges at every level, pending only at level 2
    for (int l = 1; l <= 3; l++) begin
      @(posedge clock);
      iack_in_req <= 1'b1;
      iack_in_level <= 3'(l);
      @(posedge clock);
      #1 chk("vector", {23'h0, 1'b1, 7'h2A, l != 2}, {23'h0, iack_out_valid, iack_out_vector});
    end
    @(posedge clock);
    iack_in_req <= 1'b0;
    raise <= 3'b111;
    repeat (20) @(posedge clock);
    chk("acks", 32'h0, 32'(rises));
    acc(1'b1, VISTAT_IRQ_ENABLE_OFS, 32'hA);
    poll(VISTAT_IRQ_STATUS_OFS, 32'hA);
    rd(VISTAT_LEVEL3_VECTOR_OFS, 32'h0000_00C3);
    rd(VISTAT_LEVEL1_VECTOR_OFS, 32'h0000_01C1);
    rd(VISTAT_LEVEL2_VECTOR_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    acc(1'b1, VISTAT_INT_MASK_OFS, 32'hE);
    repeat (2) @(posedge clock);
    chk("irq", 32'h1, {31'h0, irq});
    rd(VISTAT_INT_STATUS_OFS, 32'hA);
    repeat (2) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    rd(VISTAT_INT_STATUS_OFS, 32'h0);
    // Lines stay up, yet no new acknowledge until status is cleared
    n0 = rises;
    repeat (20) @(posedge clock);
    chk("acks", 32'(n0), 32'(rises));
    acc(1'b1, VISTAT_IRQ_STATUS_OFS, 32'h2);
    poll(VISTAT_IRQ_STATUS_OFS, 32'hA);
    chk("acks", 32'(n0 + 1), 32'(rises));
    // Partial writes keep the lanes that are not enabled
    avs_byteenable <= 4'h2;
    acc(1'b1, VISTAT_IRQ_ENABLE_OFS, 32'h0);
    acc(1'b1, VISTAT_OUTGOING_VECTOR_OFS, 32'h0);
    avs_byteenable <= 4'hF;
    rd(VISTAT_IRQ_ENABLE_OFS, 32'hA);
    rd(VISTAT_OUTGOING_VECTOR_OFS, 32'h5500_0000);
    conclude;
  end
endmodule
